// File: pkg/ait_pkg.sv
// package with register map, command layout and reply codes for the tunnelled i2c requests
package ait_pkg;
  // software register offsets of the source end
  localparam logic [11:0] CMD_OFFSET      = 12'h100;  // side_band_command
  localparam logic [11:0] WDATA_OFFSET    = 12'h104;  // write payload entry
  localparam logic [11:0] TADDR_OFFSET    = 12'h108;  // side_band_target_address
  localparam logic [11:0] STATUS_OFFSET   = 12'h130;  // sticky event status
  localparam logic [11:0] IRQ_CLR_OFFSET  = 12'h134;  // write one to clear
  localparam logic [11:0] IRQ_EN_OFFSET   = 12'h138;  // interrupt enable
  localparam logic [11:0] REPLY_OFFSET    = 12'h13C;  // last reply and busy
  localparam logic [11:0] RDATA_OFFSET    = 12'h140;  // read data entries start
  // command word fields
  localparam int LEN_LSB  = 0;   // length field [3:0]
  localparam int LEN_W    = 4;
  localparam int OP_LSB   = 8;   // request kind [10:8]
  localparam int OP_W     = 3;
  localparam int MOT_BIT  = 11;  // middle_of_transaction_flag
  localparam int NOPL_BIT = 12;  // request without payload
  // request kinds carried in the op field
  localparam logic [2:0] OP_WRITE  = 3'h0;
  localparam logic [2:0] OP_READ   = 3'h1;
  localparam logic [2:0] OP_WSTAT  = 3'h2;
  // reply codes from the sink
  localparam logic [1:0] RPL_ACK   = 2'h0;
  localparam logic [1:0] RPL_NACK  = 2'h1;
  localparam logic [1:0] RPL_DEFER = 2'h2;
  localparam logic [1:0] RPL_PACK  = 2'h3;
  // event bits of the status register
  localparam int EV_DONE  = 0;  // ack with data or ack
  localparam int EV_NACK  = 1;
  localparam int EV_DEFER = 2;
  localparam int EV_PACK  = 3;
  localparam int EV_W     = 4;
  localparam int MAX_BYTES = 16;  // length field is bytes minus one
  // sink i2c emulation: cycles per byte on its bus
  localparam int I2C_BYTE_NS     = 90000;
  localparam int CLK_NS          = 10;
  localparam int I2C_BYTE_CYCLES = I2C_BYTE_NS / CLK_NS;
  localparam int SINK_ADDR_W     = 7;
  // bus states of the sink's i2c side
  typedef enum logic [1:0] {AIT_BUS_IDLE, AIT_BUS_RD, AIT_BUS_WR} ait_bus_e;
endpackage

// File: pkg/ait_if.sv
// interface carrying one request and one reply between source and sink
`timescale 1ns/1ps
`default_nettype none
interface ait_if;
  import ait_pkg::*;
  logic       req_valid;   // request pulse, one cycle
  logic [2:0] req_op;      // request kind
  logic       req_mot;     // middle_of_transaction_flag
  logic       req_nopl;    // address-only / no payload
  logic [6:0] req_taddr;   // i2c target
  logic [3:0] req_len;     // bytes minus one
  logic [7:0] req_data;    // write byte, streamed after req_valid
  logic       req_dvalid;  // write byte strobe
  logic       rpl_valid;   // reply pulse
  logic [1:0] rpl_code;    // reply code
  logic [7:0] rpl_data;    // read byte
  logic       rpl_dvalid;  // read byte strobe
  modport source (output req_valid, req_op, req_mot, req_nopl, req_taddr, req_len, req_data, req_dvalid,
                  input rpl_valid, rpl_code, rpl_data, rpl_dvalid);
  modport sink (input req_valid, req_op, req_mot, req_nopl, req_taddr, req_len, req_data, req_dvalid,
                output rpl_valid, rpl_code, rpl_data, rpl_dvalid);
endinterface
`default_nettype wire

// File: rtl/ait_byte_timer.sv
// countdown that paces one emulated i2c byte on the sink side
`timescale 1ns/1ps
`default_nettype none
module ait_byte_timer
  import ait_pkg::*;
(
  input  wire logic MCLK,
  input  wire logic RST_B,
  input  wire logic start,  // load the count
  output logic      tick    // one-cycle end pulse
);
  logic [15:0] cnt_r;  // cycles left
  logic        run_r;  // counting
  // count down and pulse at zero
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      cnt_r <= 16'h0000;
      run_r <= 1'b0;
      tick  <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (start) begin
        cnt_r <= 16'(I2C_BYTE_CYCLES - 1);
        run_r <= 1'b1;
      end else if (run_r) begin
        if (cnt_r == 16'h0000) begin
          run_r <= 1'b0;
          tick  <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 16'h0001;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: rtl/ait_sink.sv
// sink end: bridges tunnelled requests onto an emulated i2c bus
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module ait_sink
  import ait_pkg::*;
(
  input  wire logic MCLK,
  input  wire logic RST_B,
  ait_if.sink       LNK,
  output logic      I2C_START,  // start or repeated start issued
  output logic      I2C_STOP,   // stop issued
  output logic      I2C_BUSY    // i2c transfer in flight
);
  ait_bus_e   bus_r;       // direction the bus is left in
  logic [6:0] cur_r;       // target of the open transfer
  logic [4:0] left_r;      // bytes still on the i2c bus
  logic       mot_r;       // keep bus after burst
  logic       tstart;      // byte timer start
  logic       tick;        // byte finished
  logic [7:0] seed_r;      // read data pattern
  logic [4:0] rlen_r;      // read bytes to return
  logic       first;       // new address phase needed
  logic       pend_r;      // deferred request awaiting its repeat
  logic [2:0] pop_r;       // kind of the pending request
  logic [3:0] plen_r;      // length of the pending request
  logic       data_req;    // request carrying or asking for bytes
  logic       repeat_hit;  // identical repeat of the pending request
  assign first      = (bus_r == AIT_BUS_IDLE) || (cur_r != LNK.req_taddr);
  assign data_req   = LNK.req_valid && !LNK.req_nopl && (LNK.req_op != OP_WSTAT);
  assign repeat_hit = pend_r && (cur_r == LNK.req_taddr) && (pop_r == LNK.req_op) &&
                      (plen_r == LNK.req_len);
  // a repeat only answers, so only a fresh request starts the bytes
  assign tstart     = (data_req && left_r == 5'h00 && !repeat_hit) || (tick && left_r > 5'h01);
  ait_byte_timer u_ait_byte_timer (.MCLK(MCLK), .RST_B(RST_B), .start(tstart), .tick(tick));
  // bus state, byte progress and replies
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      bus_r          <= AIT_BUS_IDLE;
      cur_r          <= 7'h00;
      left_r         <= 5'h00;
      mot_r          <= 1'b0;
      pend_r         <= 1'b0;
      pop_r          <= OP_WRITE;
      plen_r         <= 4'h0;
      seed_r         <= 8'h00;
      rlen_r         <= 5'h00;
      LNK.rpl_valid  <= 1'b0;
      LNK.rpl_code   <= RPL_ACK;
      LNK.rpl_data   <= 8'h00;
      LNK.rpl_dvalid <= 1'b0;
      I2C_START      <= 1'b0;
      I2C_STOP       <= 1'b0;
      I2C_BUSY       <= 1'b0;
    end else begin
      LNK.rpl_valid  <= 1'b0;
      LNK.rpl_dvalid <= 1'b0;
      I2C_START      <= 1'b0;
      I2C_STOP       <= 1'b0;
      // stream out read data after an ack
      if (rlen_r != 5'h00) begin
        LNK.rpl_dvalid <= 1'b1;
        LNK.rpl_data   <= seed_r;
        seed_r         <= seed_r + 8'h01;
        rlen_r         <= rlen_r - 5'h01;
      end
      // one byte done on the i2c side
      if (tick && left_r != 5'h00) begin
        left_r <= left_r - 5'h01;
        if (left_r == 5'h01) begin
          I2C_BUSY <= 1'b0;
          if (!mot_r) begin
            I2C_STOP <= 1'b1;
            bus_r    <= AIT_BUS_IDLE;
          end
        end
      end
      if (LNK.req_valid) begin
        LNK.rpl_valid <= 1'b1;
        if (LNK.req_nopl && LNK.req_op != OP_WSTAT) begin
          // address-only: abort or stop, no bytes
          left_r       <= 5'h00;
          I2C_BUSY     <= 1'b0;
          pend_r       <= 1'b0;
          LNK.rpl_code <= RPL_ACK;
          if (!LNK.req_mot) begin
            I2C_STOP <= 1'b1;
            bus_r    <= AIT_BUS_IDLE;
          end else begin
            I2C_START <= 1'b1;
            cur_r     <= LNK.req_taddr;
            bus_r     <= (LNK.req_op == OP_READ) ? AIT_BUS_RD : AIT_BUS_WR;
          end
        end else if (LNK.req_op == OP_WSTAT) begin
          // poll: no start; mot clear stops at once if no bytes are left and the bus is held, else at burst end
          if (!LNK.req_mot) begin
            mot_r <= 1'b0;
            if (left_r == 5'h00 && bus_r != AIT_BUS_IDLE) begin
              I2C_STOP <= 1'b1;
              bus_r    <= AIT_BUS_IDLE;
            end
          end
          if (left_r != 5'h00) begin
            LNK.rpl_code <= RPL_PACK;
          end else if (pend_r && pop_r == OP_WRITE && cur_r == LNK.req_taddr) begin
            LNK.rpl_code <= RPL_ACK;
          end else begin
            LNK.rpl_code <= RPL_NACK;
          end
        end else if (left_r != 5'h00) begin
          // still busy with the previous transfer
          LNK.rpl_code <= (LNK.req_op == OP_READ) ? RPL_DEFER : RPL_PACK;
        end else if (repeat_hit) begin
          // identical repeat after the i2c side finished
          LNK.rpl_code <= RPL_ACK;
          pend_r       <= 1'b0;
          if (LNK.req_op == OP_READ) begin
            rlen_r <= {1'b0, LNK.req_len} + 5'h01;
          end
        end else begin
          // launch bytes; any other request drops the pending one
          I2C_START    <= first;
          cur_r        <= LNK.req_taddr;
          mot_r        <= LNK.req_mot;
          I2C_BUSY     <= 1'b1;
          bus_r        <= (LNK.req_op == OP_READ) ? AIT_BUS_RD : AIT_BUS_WR;
          left_r       <= {1'b0, LNK.req_len} + 5'h01;
          pend_r       <= 1'b1;
          pop_r        <= LNK.req_op;
          plen_r       <= LNK.req_len;
          LNK.rpl_code <= RPL_DEFER;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: rtl/ait_source.sv
// source end: software registers that build and launch tunnelled i2c requests
`timescale 1ns/1ps
`default_nettype none
module ait_source
  import ait_pkg::*;
(
  input  wire logic        MCLK,
  input  wire logic        RST_B,
  ait_if.source            LNK,
  input  wire logic [11:0] ADDR,    // register byte address
  input  wire logic [31:0] WDATA,   // write data
  input  wire logic        WR,      // write strobe
  input  wire logic        RD,      // read strobe
  output logic      [31:0] RDATA,   // read data, cycle after RD
  output logic             IRQ      // level interrupt
);
  logic [31:0]     cmd_r;                 // side_band_command
  logic [31:0]     taddr_r;               // side_band_target_address
  logic [7:0]      wbuf_r [MAX_BYTES];    // write payload
  logic [7:0]      rbuf_r [MAX_BYTES];    // returned read data
  logic [3:0]      wcnt_r;                // payload fill pointer
  logic [3:0]      rcnt_r;                // read data pointer
  logic [4:0]      send_r;                // payload bytes left to stream
  logic [3:0]      sidx_r;                // payload stream index
  logic [EV_W-1:0] stat_r;                // sticky events
  logic [EV_W-1:0] en_r;                  // interrupt enables
  logic [EV_W-1:0] ev;                    // this cycle's events
  logic [1:0]      last_r;                // last reply code
  logic            busy_r;                // request awaiting reply
  logic            pend_r;                // deferred or partially acked op outstanding
  logic            launch;                // command register written
  assign launch = WR && (ADDR == CMD_OFFSET) && !busy_r;
  // reply events
  always_comb begin
    ev = '0;
    if (LNK.rpl_valid) begin
      ev[EV_DONE]  = (LNK.rpl_code == RPL_ACK);
      ev[EV_NACK]  = (LNK.rpl_code == RPL_NACK);
      ev[EV_DEFER] = (LNK.rpl_code == RPL_DEFER);
      ev[EV_PACK]  = (LNK.rpl_code == RPL_PACK);
    end
  end
  // software register writes
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      cmd_r <= 32'h0000_0000; taddr_r <= 32'h0000_0000; en_r <= '0; wcnt_r <= 4'h0;
    end else if (WR) begin
      case (ADDR)
        CMD_OFFSET:   if (!busy_r) cmd_r <= WDATA;
        TADDR_OFFSET: taddr_r <= WDATA;
        IRQ_EN_OFFSET: en_r <= WDATA[EV_W-1:0];
        WDATA_OFFSET: wcnt_r <= wcnt_r + 4'h1;
        default: ;
      endcase
      if (launch) wcnt_r <= 4'h0;
    end
  end
  // payload storage
  always_ff @(posedge MCLK) begin
    if (WR && ADDR == WDATA_OFFSET) wbuf_r[wcnt_r] <= WDATA[7:0];
    if (LNK.rpl_dvalid) rbuf_r[rcnt_r] <= LNK.rpl_data;
  end
  // sticky status, set wins over clear
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      stat_r <= '0;
      IRQ    <= 1'b0;
    end else begin
      stat_r <= (stat_r & ~((WR && ADDR == IRQ_CLR_OFFSET) ? WDATA[EV_W-1:0] : '0)) | ev;
      IRQ    <= |(stat_r & en_r);
    end
  end
  // request launch and payload streaming onto the link
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      LNK.req_valid <= 1'b0; LNK.req_op <= OP_WRITE; LNK.req_mot <= 1'b0; LNK.req_nopl <= 1'b0;
      LNK.req_taddr <= 7'h00; LNK.req_len <= 4'h0; LNK.req_data <= 8'h00; LNK.req_dvalid <= 1'b0;
      send_r <= 5'h00; sidx_r <= 4'h0; busy_r <= 1'b0; last_r <= RPL_ACK; pend_r <= 1'b0; rcnt_r <= 4'h0;
    end else begin
      LNK.req_valid  <= 1'b0;
      LNK.req_dvalid <= 1'b0;
      if (launch) begin
        // the same command repeated is a retry; an address-only request, or another data request once the bytes are done, aborts the pending one
        LNK.req_valid <= 1'b1;
        LNK.req_op    <= WDATA[OP_LSB +: OP_W];
        LNK.req_mot   <= WDATA[MOT_BIT];
        LNK.req_nopl  <= WDATA[NOPL_BIT];
        LNK.req_taddr <= taddr_r[SINK_ADDR_W-1:0];
        LNK.req_len   <= WDATA[LEN_LSB +: LEN_W];
        busy_r <= 1'b1; rcnt_r <= 4'h0; sidx_r <= 4'h0;
        send_r <= (WDATA[OP_LSB +: OP_W] == OP_WRITE && !WDATA[NOPL_BIT]) ?
                  {1'b0, WDATA[LEN_LSB +: LEN_W]} + 5'h01 : 5'h00;
      end else if (send_r != 5'h00) begin
        LNK.req_dvalid <= 1'b1; LNK.req_data <= wbuf_r[sidx_r];
        sidx_r <= sidx_r + 4'h1; send_r <= send_r - 5'h01;
      end
      if (LNK.rpl_dvalid) rcnt_r <= rcnt_r + 4'h1;
      if (LNK.rpl_valid) begin
        busy_r <= 1'b0; last_r <= LNK.rpl_code;
        pend_r <= (LNK.rpl_code == RPL_DEFER) || (LNK.rpl_code == RPL_PACK);
      end
    end
  end
  // register read data, one cycle after the strobe
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      RDATA <= 32'h0000_0000;
    end else if (RD) begin
      if (ADDR >= RDATA_OFFSET && ADDR < RDATA_OFFSET + 12'(4 * MAX_BYTES)) begin
        RDATA <= {24'h000000, rbuf_r[ADDR[5:2]]};
      end else begin
        case (ADDR)
          CMD_OFFSET:    RDATA <= cmd_r;
          TADDR_OFFSET:  RDATA <= taddr_r;
          STATUS_OFFSET: RDATA <= {28'h0000000, stat_r};
          IRQ_EN_OFFSET: RDATA <= {28'h0000000, en_r};
          REPLY_OFFSET:  RDATA <= {23'h000000, rcnt_r, pend_r, busy_r, last_r, 1'b0};
          default:       RDATA <= 32'h0000_0000;
        endcase
      end
    end else begin
      RDATA <= 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

// File: tb/ait_checker.sv
// concurrent checks on the link between source and sink ends
`timescale 1ns/1ps
`default_nettype none
module ait_checker
  import ait_pkg::*;
(
  input wire logic       MCLK,
  input wire logic       RST_B,
  input wire logic       req_valid,
  input wire logic [2:0] req_op,
  input wire logic       req_mot,
  input wire logic       req_nopl,
  input wire logic [3:0] req_len,
  input wire logic       req_dvalid,
  input wire logic       rpl_valid,
  input wire logic [1:0] rpl_code,
  input wire logic       rpl_dvalid,
  input wire logic       I2C_START,
  input wire logic       I2C_STOP,
  input wire logic       I2C_BUSY
);
  // one clock domain, reset low
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  a_reply_next_cycle: assert property (req_valid |=> rpl_valid)
    else $error("reply missing after request");
  a_reply_has_cause: assert property (rpl_valid |-> $past(req_valid))
    else $error("reply without request");
  a_nopl_no_bytes: assert property (req_valid && req_nopl |=> !req_dvalid [*8])
    else $error("payload byte on no-payload request");
  a_addr_only_stop: assert property (req_valid && req_nopl && !req_mot && req_op != OP_WSTAT |-> ##[1:3] I2C_STOP)
    else $error("address-only request gave no stop");
  a_wstat_quiet: assert property (req_valid && req_op == OP_WSTAT && req_mot |=> !I2C_START [*4])
    else $error("write status started i2c activity");
  a_busy_read_defer: assert property (req_valid && req_op == OP_READ && !req_nopl && I2C_BUSY |=> rpl_code == RPL_DEFER)
    else $error("busy read not deferred");
  a_busy_wstat_pack: assert property (req_valid && req_op == OP_WSTAT && I2C_BUSY |=> rpl_code == RPL_PACK)
    else $error("busy write status not partial ack");
  a_read_ack_bytes: assert property (req_valid && req_op == OP_READ && !req_nopl && req_len == 4'h0 ##1
    rpl_valid && rpl_code == RPL_ACK |=> rpl_dvalid ##1 !rpl_dvalid)
    else $error("single byte read returned wrong byte count");
  a_start_pulse: assert property ($rose(I2C_START) |=> !I2C_START)
    else $error("start longer than one cycle");
  // main scenarios reached
  c_defer: cover property (rpl_valid && rpl_code == RPL_DEFER);
  c_read_data: cover property (rpl_dvalid);
  c_pack: cover property (rpl_valid && rpl_code == RPL_PACK);
endmodule
`default_nettype wire

// File: tb/test_aux_i2c_tunnel_requests.sv
// self-checking bench joining source and sink ends with a request model
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin n_fail++; \
  $display("BAD %s exp %0h got %0h", nm, ex, gt); end end
module test_aux_i2c_tunnel_requests;
  import ait_pkg::*;
  logic        MCLK = 1'b0;   // system clock
  logic        RST_B = 1'b0;  // reset, active low
  logic        WR = 1'b0;     // register write strobe
  logic        RD = 1'b0;     // register read strobe
  logic [11:0] ADDR = 12'h000;
  logic [31:0] WDATA = 32'h0;
  logic [31:0] RDATA;
  logic        IRQ, I2C_START, I2C_STOP, I2C_BUSY;
  logic        got = 1'b0;    // reply seen
  logic [1:0]  code;          // last reply code
  logic [6:0]  ta_a, ta_b;    // random targets
  logic [7:0]  byt;           // random payload
  int n_fail = 0, n_compared = 0, cyc = 0, nbytes = 0, nstop = 0, ns0;
  int pend = 0, p_op = 0, p_ad = 0, busy_until = 0;  // model state
  ait_if lnk();
  ait_source u_ait_source (.MCLK(MCLK), .RST_B(RST_B), .LNK(lnk), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .IRQ(IRQ));
  ait_sink u_ait_sink (.MCLK(MCLK), .RST_B(RST_B), .LNK(lnk), .I2C_START(I2C_START), .I2C_STOP(I2C_STOP),
    .I2C_BUSY(I2C_BUSY));
  ait_checker u_ait_checker (.MCLK(MCLK), .RST_B(RST_B), .req_valid(lnk.req_valid), .req_op(lnk.req_op),
    .req_mot(lnk.req_mot), .req_nopl(lnk.req_nopl), .req_len(lnk.req_len), .req_dvalid(lnk.req_dvalid),
    .rpl_valid(lnk.rpl_valid), .rpl_code(lnk.rpl_code), .rpl_dvalid(lnk.rpl_dvalid),
    .I2C_START(I2C_START), .I2C_STOP(I2C_STOP), .I2C_BUSY(I2C_BUSY));
  // clock
  always #5 MCLK = ~MCLK;
  // reply monitor and hang guard
  always @(posedge MCLK) begin
    cyc++;
    if (lnk.rpl_valid === 1'b1) begin
      got <= 1'b1;
      code <= lnk.rpl_code;
    end
    if (lnk.rpl_dvalid === 1'b1) nbytes++;
    if (I2C_STOP === 1'b1) nstop++;
    if (cyc == 60000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  // verdict and end of run
  task automatic tally_and_finish();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one register write, then a gap cycle
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
    @(posedge MCLK);
  endtask
  // one register read, masked compare in the following cycle
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    #1 `CHK(nm, e, RDATA & m)
    @(posedge MCLK);
  endtask
  // launch a request, model its reply, compare code and byte count
  task automatic req(input logic [2:0] op, input logic middle_of_transaction_flag, input logic nopl, input logic [6:0] ta);
    logic [1:0] ec;
    int nb0;
    if (nopl) begin
      if (op == OP_WSTAT && cyc < busy_until) ec = RPL_PACK;
      else if (op == OP_WSTAT) ec = (pend == 1 && p_op == int'(OP_WRITE) && p_ad == int'(ta)) ? RPL_ACK : RPL_NACK;
      else begin
        ec = RPL_ACK;
        pend = 0;
        busy_until = 0;
      end
    end else if (cyc < busy_until) ec = (op == OP_READ) ? RPL_DEFER : RPL_PACK;
    else if (pend == 1 && p_op == int'(op) && p_ad == int'(ta)) begin
      ec = RPL_ACK;
      pend = 0;
    end else begin
      ec = RPL_DEFER;
      pend = 1;
      p_op = int'(op);
      p_ad = int'(ta);
      busy_until = cyc + I2C_BYTE_CYCLES;
    end
    wr(TADDR_OFFSET, {25'h0, ta});
    if (!nopl && op == OP_WRITE) wr(WDATA_OFFSET, {24'h0, byt});
    got = 1'b0;
    nb0 = nbytes;
    wr(CMD_OFFSET, {19'h0, nopl, middle_of_transaction_flag, op, 8'h00});
    for (int i = 0; i < 20 && got !== 1'b1; i++) @(posedge MCLK);
    repeat (4) @(posedge MCLK);
    `CHK("reply seen", 1'b1, got)
    `CHK("reply code", ec, code)
    `CHK("read bytes", (ec == RPL_ACK && op == OP_READ && !nopl) ? 1 : 0, nbytes - nb0)
  endtask
  // main sequence
  initial begin
    void'($urandom(45012));
    ta_a = 7'($urandom);
    ta_b = ta_a ^ 7'h01;
    byt = 8'($urandom);
    repeat (5) @(posedge MCLK);
    RST_B <= 1'b1;
    repeat (2) @(posedge MCLK);
    req(OP_READ, 1'b0, 1'b0, ta_a);
    rd(STATUS_OFFSET, 32'h4, 32'h4, "defer event");
    wr(IRQ_EN_OFFSET, 32'h4);
    @(posedge MCLK);
    #1 `CHK("irq raised", 1'b1, IRQ)
    wr(IRQ_CLR_OFFSET, 32'h4);
    @(posedge MCLK);
    #1 `CHK("irq cleared", 1'b0, IRQ)
    rd(STATUS_OFFSET, 32'h4, 32'h0, "defer cleared");
    rd(12'h1F0, 32'hFFFFFFFF, 32'h0, "unmapped");
    req(OP_READ, 1'b0, 1'b0, ta_a);
    repeat (9100) @(posedge MCLK);
    req(OP_READ, 1'b0, 1'b0, ta_a);
    rd(REPLY_OFFSET, 32'h1FE, 32'h20, "reply word");
    `CHK("read stop", 1'b1, nstop > 0)
    req(OP_WRITE, 1'b1, 1'b0, ta_b);
    req(OP_WSTAT, 1'b1, 1'b1, ta_b);
    repeat (9100) @(posedge MCLK);
    req(OP_WSTAT, 1'b1, 1'b1, ta_b);
    req(OP_WRITE, 1'b1, 1'b0, ta_b);
    req(OP_WSTAT, 1'b1, 1'b1, ta_b);
    ns0 = nstop;
    req(OP_WRITE, 1'b0, 1'b1, ta_b);
    `CHK("addr only stop", 1'b1, nstop > ns0)
    req(OP_READ, 1'b0, 1'b0, ta_a);
    req(OP_READ, 1'b0, 1'b1, ta_a);
    req(OP_READ, 1'b0, 1'b0, ta_a);
    repeat (9100) @(posedge MCLK);
    req(OP_WRITE, 1'b0, 1'b0, ta_a);
    repeat (9100) @(posedge MCLK);
    req(OP_READ, 1'b0, 1'b0, ta_a);
    tally_and_finish();
  end
endmodule
`default_nettype wire
